/* File: rtl/drf_pkg.sv */
// Purpose: Shared constants for the DRAM refresh control block.
// Assumes: Wishbone classic slave with 32-bit data and byte addressing.
// Notes:   Registers are 16 bits wide and sit in the low half of each word.
package drf_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] ADR_INTERVAL = 8'h00;
  localparam logic [7:0] ADR_CONTROL = 8'h04;
  localparam logic [7:0] ADR_BASE = 8'h08;
  localparam logic [7:0] ADR_ROWCNT = 8'h0C;
  localparam logic [7:0] ADR_PIN_CONFIG_REGISTER = 8'h10;

  ////////////////////////////////////////////////////////////////////////
  // Field layout.
  localparam int INTERVAL_W = 10;
  localparam int BASE_W = 12;
  localparam int ROWCNT_W = 13;
  localparam int ROWCNT_LSB = 1;
  localparam int ADDR_W = 26;
  localparam int CTRL_EN_BIT = 15;
  localparam int PIN_CONFIG_REGISTER_REFRESH_BIT = 6;
  localparam int PIN_CONFIG_REGISTER_W = 8;

  ////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [INTERVAL_W-1:0] RST_INTERVAL = 10'h000;
  localparam logic [BASE_W-1:0] RST_BASE = 12'h000;
  localparam logic [ROWCNT_W-1:0] RST_ROWCNT = 13'h0000;
  localparam logic [PIN_CONFIG_REGISTER_W-1:0] RST_PIN_CONFIG_REGISTER = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Timing: one refresh cycle holds the bus for this many clocks.
  localparam int REFRESH_CYCLES = 2;
  localparam logic [INTERVAL_W-1:0] CNT_ONE = 10'h001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_YIELD = 3'b010,
    ST_RUN = 3'b100
  } drf_state_t;

endpackage : drf_pkg

/* File: rtl/drf_tmr_if.sv */
// Purpose: Carries the interval timer controls and results.
// Assumes: Single clock domain shared by both ends.
// Notes:   The tick is combinational and lasts one cycle.
`timescale 1ns/1ps
interface drf_tmr_if;
  import drf_pkg::*;
  logic enable;
  logic load;
  logic pending;
  logic [INTERVAL_W-1:0] reload;
  logic [INTERVAL_W-1:0] count;
  logic tick;

  modport timer (input enable, input load, input pending, input reload,
                 output count, output tick);
  modport ctrl (output enable, output load, output pending, output reload,
                input count, input tick);
endinterface : drf_tmr_if

/* File: rtl/drf_interval_timer.sv */
// Purpose: Down-counting refresh interval timer.
// Assumes: The controller holds load high for one cycle on new settings.
// Notes:   A reload value of zero or one fires on every cycle that pending is low.
`timescale 1ns/1ps
module drf_interval_timer
  import drf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  drf_tmr_if.timer tmr
);

  logic [INTERVAL_W-1:0] count_ff;
  logic at_one;

  assign at_one = (count_ff <= CNT_ONE);
  assign tmr.count = count_ff;

  ////////////////////////////////////////////////////////////////////////
  // Request at one unless pending.
  assign tmr.tick = tmr.enable && !tmr.load && at_one && !tmr.pending;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_ff <= RST_INTERVAL;
    else if (tmr.load || !tmr.enable || at_one)
      count_ff <= tmr.reload;
    else
      count_ff <= count_ff - CNT_ONE;
  end

  ////////////////////////////////////////////////////////////////////////
  tick_at_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr.tick |-> at_one && tmr.enable)
    else $error("Tick raised away from count one.");

  reload_after_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr.tick && $stable(tmr.reload) |=> count_ff == $past(tmr.reload))
    else $error("Timer did not reload after a request.");

endmodule : drf_interval_timer

/* File: rtl/drf_refresh_ctrl.sv */
// Purpose: Refresh control unit with interval timer, row counter and arbiter.
// Assumes: Hold and DMA masters drop their request once acknowledge falls.
// Notes:   The processor reports bus idle so a refresh never cuts a cycle.
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - Row counter holds address bits 13:1.
// - Lowest address bit set during refresh.
// - Both byte enables high during refresh.
// - Refresh request withdraws hold or DMA acknowledge.
// - Request stays pending until bus obtained.
// - Refresh wins over every other requester.
// - Interval below six starves other masters.
// - Row counter advances at each request.
// - Refresh indication low through each cycle.
// - Pin config bit 6 routes indication.
// - Control bit 15 enables the unit.
// - Interval value is ten low bits.
// - Control bits 9:0 read running count.
// - Row addresses driven even for CBR.
// - Timer requests at one unless pending.
// - Base supplies address bits 25:14.
module drf_refresh_ctrl
  import drf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpu_bus_idle_i,
  input wire logic cpu_ble_n_i,
  input wire logic cpu_bhe_n_i,
  input wire logic hold_request_i,
  input wire logic dma_request_i,
  input wire logic chip_select_six_n_i,
  output logic hold_acknowledge_o,
  output logic dma_acknowledge_n_o,
  output logic low_byte_enable_n_o,
  output logic high_byte_enable_n_o,
  output logic [ADDR_W-1:0] refresh_addr_o,
  output logic refresh_n_o,
  output logic cs6_refresh_pin_n_o
);

  ////////////////////////////////////////////////////////////////////////
  // Register file state.
  logic [INTERVAL_W-1:0] interval_ff;
  logic enable_ff;
  logic [BASE_W-1:0] base_ff;
  logic [ROWCNT_W-1:0] rowcnt_ff;
  logic [PIN_CONFIG_REGISTER_W-1:0] pin_config_register_ff;
  logic load_ff;
  logic pending_ff;
  drf_state_t state_ff;
  drf_state_t nxt_state;
  logic [7:0] run_cnt_ff;
  logic bus_wr;
  logic bus_rd;
  logic start_run;
  logic ext_owned;
  logic release_wait_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] wr_interval;
  logic [15:0] wr_base;
  logic [15:0] wr_rowcnt;

  drf_tmr_if tmr ();

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction : hit

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : merge16

  assign wr_interval = merge16({6'h00, interval_ff}, wb_dat_i, wb_sel_i);
  assign wr_base = merge16({4'h0, base_ff}, wb_dat_i, wb_sel_i);
  assign wr_rowcnt = merge16({2'b00, rowcnt_ff, 1'b0}, wb_dat_i, wb_sel_i);

  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign bus_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone answer: one wait state, ack for one cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_comb
  begin
    nxt_rdata = 16'h0000;
    if (hit(wb_adr_i, ADR_INTERVAL))
      nxt_rdata[INTERVAL_W-1:0] = interval_ff;
    else if (hit(wb_adr_i, ADR_CONTROL))
    begin
      nxt_rdata[CTRL_EN_BIT] = enable_ff;
      nxt_rdata[INTERVAL_W-1:0] = tmr.count;
    end
    else if (hit(wb_adr_i, ADR_BASE))
      nxt_rdata[BASE_W-1:0] = base_ff;
    else if (hit(wb_adr_i, ADR_ROWCNT))
      nxt_rdata[ROWCNT_W+ROWCNT_LSB-1:ROWCNT_LSB] = rowcnt_ff;
    else if (hit(wb_adr_i, ADR_PIN_CONFIG_REGISTER))
      nxt_rdata[PIN_CONFIG_REGISTER_W-1:0] = pin_config_register_ff;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_rd)
      wb_dat_o <= {16'h0000, nxt_rdata};
    else
      wb_dat_o <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers. A new interval or a fresh enable reloads the timer.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      interval_ff <= RST_INTERVAL;
      enable_ff <= 1'b0;
      base_ff <= RST_BASE;
      pin_config_register_ff <= RST_PIN_CONFIG_REGISTER;
      load_ff <= 1'b0;
    end
    else
    begin
      load_ff <= 1'b0;
      if (bus_wr && hit(wb_adr_i, ADR_INTERVAL))
      begin
        interval_ff <= wr_interval[INTERVAL_W-1:0];
        load_ff <= 1'b1;
      end
      if (bus_wr && hit(wb_adr_i, ADR_CONTROL) && wb_sel_i[1])
      begin
        enable_ff <= wb_dat_i[CTRL_EN_BIT];
        load_ff <= 1'b1;
      end
      if (bus_wr && hit(wb_adr_i, ADR_BASE))
        base_ff <= wr_base[BASE_W-1:0];
      if (bus_wr && hit(wb_adr_i, ADR_PIN_CONFIG_REGISTER) && wb_sel_i[0])
        pin_config_register_ff <= wb_dat_i[PIN_CONFIG_REGISTER_W-1:0];
    end
  end

  assign tmr.enable = enable_ff;
  assign tmr.load = load_ff;
  assign tmr.reload = interval_ff;
  assign tmr.pending = pending_ff;

  drf_interval_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tmr(tmr.timer)
  );

  ////////////////////////////////////////////////////////////////////////
  // Row counter. A refresh step beats a software write in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rowcnt_ff <= RST_ROWCNT;
    else if (tmr.tick)
      rowcnt_ff <= rowcnt_ff + 13'h0001;
    else if (bus_wr && hit(wb_adr_i, ADR_ROWCNT))
      rowcnt_ff <= wr_rowcnt[ROWCNT_W+ROWCNT_LSB-1:ROWCNT_LSB];
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending request: a new tick wins over the clear at bus takeover.
  assign start_run = (nxt_state == ST_RUN) && (state_ff != ST_RUN);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pending_ff <= 1'b0;
    else if (tmr.tick)
      pending_ff <= 1'b1;
    else if (start_run)
      pending_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Arbitration. A granted master keeps the bus until its acknowledge falls
  // and both hold and DMA requests are low. A master that only requests and was
  // never granted does not own the bus; it holds off a refresh only by keeping another master's release wait open.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      release_wait_ff <= 1'b0;
    else if (hold_acknowledge_o || !dma_acknowledge_n_o)
      release_wait_ff <= 1'b1;
    else if (!hold_request_i && !dma_request_i)
      release_wait_ff <= 1'b0;
  end

  assign ext_owned = hold_acknowledge_o || !dma_acknowledge_n_o || release_wait_ff;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (pending_ff)
          nxt_state = ST_YIELD;
      ST_YIELD:
        // Wait for the external master to let go.
        if (!ext_owned && cpu_bus_idle_i)
          nxt_state = ST_RUN;
      ST_RUN:
        if (run_cnt_ff == 8'(REFRESH_CYCLES - 1))
          nxt_state = pending_ff ? ST_YIELD : ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || nxt_state != ST_RUN)
      run_cnt_ff <= 8'h00;
    else if (state_ff == ST_RUN)
      run_cnt_ff <= run_cnt_ff + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_acknowledge_o <= 1'b0;
      dma_acknowledge_n_o <= 1'b1;
    end
    else if (pending_ff || tmr.tick || state_ff != ST_IDLE)
    begin
      hold_acknowledge_o <= 1'b0;
      dma_acknowledge_n_o <= 1'b1;
    end
    else
    begin
      dma_acknowledge_n_o <= !(dma_request_i && cpu_bus_idle_i &&
                               (!dma_acknowledge_n_o || !hold_acknowledge_o));
      hold_acknowledge_o <= hold_request_i && cpu_bus_idle_i &&
                            dma_acknowledge_n_o && !dma_request_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Refresh cycle outputs, registered from the next state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      refresh_n_o <= 1'b1;
      refresh_addr_o <= '0;
      low_byte_enable_n_o <= 1'b1;
      high_byte_enable_n_o <= 1'b1;
    end
    else if (nxt_state == ST_RUN)
    begin
      refresh_n_o <= 1'b0;
      refresh_addr_o <= {base_ff, rowcnt_ff, 1'b1};
      low_byte_enable_n_o <= 1'b1;
      high_byte_enable_n_o <= 1'b1;
    end
    else
    begin
      refresh_n_o <= 1'b1;
      refresh_addr_o <= '0;
      low_byte_enable_n_o <= cpu_ble_n_i;
      high_byte_enable_n_o <= cpu_bhe_n_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cs6_refresh_pin_n_o <= 1'b1;
    else if (pin_config_register_ff[PIN_CONFIG_REGISTER_REFRESH_BIT])
      cs6_refresh_pin_n_o <= (nxt_state != ST_RUN);
    else
      cs6_refresh_pin_n_o <= chip_select_six_n_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks. The glue-side column buffer duty is outside this block.
  ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Bus ack stood longer than one cycle.");

  refresh_lsb_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !refresh_n_o |-> refresh_addr_o[0] == 1'b1)
    else $error("Lowest refresh address bit not set.");

  byte_enables_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !refresh_n_o |-> low_byte_enable_n_o && high_byte_enable_n_o)
    else $error("Byte enable active during refresh.");

  grant_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pending_ff |=> !hold_acknowledge_o && dma_acknowledge_n_o)
    else $error("Grant kept while refresh pending.");

  pending_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pending_ff && !start_run |=> pending_ff)
    else $error("Pending refresh lost before takeover.");

  refresh_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !refresh_n_o |-> !hold_acknowledge_o && dma_acknowledge_n_o)
    else $error("External grant during refresh.");

  row_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr.tick |=> rowcnt_ff == $past(rowcnt_ff) + 13'h0001)
    else $error("Row counter did not advance.");

  refresh_ind_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_RUN) == !refresh_n_o)
    else $error("Refresh indication does not track cycle.");

  pin_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_config_register_ff[PIN_CONFIG_REGISTER_REFRESH_BIT] && $stable(pin_config_register_ff) |-> cs6_refresh_pin_n_o == refresh_n_o)
    else $error("Shared pin not carrying refresh indication.");

  enable_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !enable_ff |-> !tmr.tick)
    else $error("Refresh request while disabled.");

  count_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_rd && hit(wb_adr_i, ADR_CONTROL) |=> wb_dat_o[9:0] == $past(tmr.count))
    else $error("Control readback lost running count.");

  base_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !refresh_n_o |-> refresh_addr_o[ADDR_W-1:ADDR_W-BASE_W] == $past(base_ff))
    else $error("Refresh address upper bits differ from base.");

  refresh_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(refresh_n_o));
  hold_yield_c: cover property (@(posedge clk_i) disable iff (rst_i)
    hold_acknowledge_o && pending_ff ##1 !hold_acknowledge_o ##[1:50] !refresh_n_o);
  dma_yield_c: cover property (@(posedge clk_i) disable iff (rst_i)
    !dma_acknowledge_n_o ##[1:50] !refresh_n_o);

endmodule : drf_refresh_ctrl

/* File: verif/drf_ext_master.sv */
// Purpose: Behavioural external bus master using hold or DMA cascade.
// Assumes: One clock shared with the refresh block.
// Notes:   Requests while want_i is high and backs off when its grant is withdrawn.
`timescale 1ns/1ps
module drf_ext_master
  import drf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic want_i,
  input wire logic use_dma_i,
  input wire logic hold_acknowledge_i,
  input wire logic dma_acknowledge_n_i,
  output logic hold_request_o,
  output logic dma_request_o
);
  logic req_ff;
  logic granted_ff;
  logic grant;

  assign grant = use_dma_i ? !dma_acknowledge_n_i : hold_acknowledge_i;
  assign hold_request_o = req_ff && !use_dma_i;
  assign dma_request_o = req_ff && use_dma_i;

  ////////////////////////////////////////////////////////////////////////
  // Drop request on lost grant.
  // Only one idle cycle is given, so the block must not wait for a longer gap.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_ff <= 1'b0;
      granted_ff <= 1'b0;
    end
    else
    begin
      granted_ff <= grant;
      req_ff <= want_i && !(granted_ff && !grant);
    end
  end
endmodule : drf_ext_master

/* File: verif/drf_refresh_ctrl_tb.sv */
// Purpose: Self-checking bench for the DRAM refresh control block.
// Assumes: The processor side always reports its bus as idle.
// Notes:   Each scenario is its own task and judges its own results.
`timescale 1ns/1ps
module drf_refresh_ctrl_tb;
  import drf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, want, use_dma, pin_exp;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic cpu_ble_n_i, cpu_bhe_n_i, hold_request_i, dma_request_i, chip_select_six_n_i;
  logic hold_acknowledge_o, dma_acknowledge_n_o, low_byte_enable_n_o, high_byte_enable_n_o;
  logic refresh_n_o, cs6_refresh_pin_n_o;
  logic [ADDR_W-1:0] refresh_addr_o, raddr;
  int mismatches = 0;
  int n_checks = 0;

  always #25 clk_i = ~clk_i;

  drf_refresh_ctrl i_drf_refresh_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_bus_idle_i(1'b1),
    .cpu_ble_n_i(cpu_ble_n_i), .cpu_bhe_n_i(cpu_bhe_n_i), .hold_request_i(hold_request_i),
    .dma_request_i(dma_request_i), .chip_select_six_n_i(chip_select_six_n_i),
    .hold_acknowledge_o(hold_acknowledge_o), .dma_acknowledge_n_o(dma_acknowledge_n_o),
    .low_byte_enable_n_o(low_byte_enable_n_o), .high_byte_enable_n_o(high_byte_enable_n_o),
    .refresh_addr_o(refresh_addr_o), .refresh_n_o(refresh_n_o),
    .cs6_refresh_pin_n_o(cs6_refresh_pin_n_o));

  drf_ext_master i_drf_ext_master (.clk_i(clk_i), .rst_i(rst_i), .want_i(want),
    .use_dma_i(use_dma), .hold_acknowledge_i(hold_acknowledge_o),
    .dma_acknowledge_n_i(dma_acknowledge_n_o), .hold_request_o(hold_request_i),
    .dma_request_o(dma_request_i));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  // Classic single cycle; the next call starts one edge later, leaving an idle cycle.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {16'h0000, dat};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    check(n < 20, "no bus answer");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wait_refresh(input int limit);
    int n;
    int low;
    n = 0;
    low = 0;
    while (refresh_n_o !== 1'b0 && n < limit)
    begin
      @(posedge clk_i);
      n++;
    end
    check(n < limit, "no refresh cycle");
    raddr = refresh_addr_o;
    while (refresh_n_o === 1'b0 && low < 8)
    begin
      check(low_byte_enable_n_o === 1'b1 && high_byte_enable_n_o === 1'b1, "enables");
      check(refresh_addr_o === raddr && raddr[0] === 1'b1, "refresh address");
      check(hold_acknowledge_o === 1'b0 && dma_acknowledge_n_o === 1'b1, "grant");
      check(cs6_refresh_pin_n_o === pin_exp, "shared pin");
      @(posedge clk_i);
      low++;
    end
    check(low == REFRESH_CYCLES, "refresh length");
  endtask : wait_refresh

  task automatic wait_grant(input int limit);
    int n;
    n = 0;
    while ((use_dma ? !dma_acknowledge_n_o : hold_acknowledge_o) !== 1'b1 && n < limit)
    begin
      @(posedge clk_i);
      n++;
    end
    check(n < limit, "master not granted");
  endtask : wait_grant

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] adrs [6];
    adrs = '{ADR_INTERVAL, ADR_CONTROL, ADR_BASE, ADR_ROWCNT, ADR_PIN_CONFIG_REGISTER, 8'h14};
    foreach (adrs[i])
    begin
      wb(1'b0, adrs[i], 16'h0000);
      check(rd === 32'h0000_0000, "value after reset");
    end
    check(refresh_n_o === 1'b1 && low_byte_enable_n_o === 1'b0, "idle outputs");
    wb(1'b1, ADR_INTERVAL, 16'hFFFF);
    wb(1'b0, ADR_INTERVAL, 16'h0000);
    check(rd === 32'h0000_03FF, "interval width");
    wb(1'b1, ADR_BASE, 16'hFFFF);
    wb(1'b0, ADR_BASE, 16'h0000);
    check(rd === 32'h0000_0FFF, "base width");
    wb(1'b1, ADR_ROWCNT, 16'hFFFF);
    wb(1'b0, ADR_ROWCNT, 16'h0000);
    check(rd === 32'h0000_3FFE, "row counter bits");
    wb(1'b1, ADR_ROWCNT, 16'h0000);
    $display("test reset and registers done");
  endtask : t_reset

  task automatic t_refresh;
    logic [12:0] row;
    int seen;
    seen = 0;
    wb(1'b1, ADR_INTERVAL, 16'h0014);
    wb(1'b1, ADR_BASE, 16'h0ABC);
    wb(1'b1, ADR_PIN_CONFIG_REGISTER, 16'h0040);
    pin_exp = 1'b0;
    wb(1'b1, ADR_CONTROL, 16'h8000);
    wb(1'b0, ADR_CONTROL, 16'h0000);
    row = rd[12:0];
    wb(1'b0, ADR_CONTROL, 16'h0000);
    check(rd[9:0] <= 10'h014 && rd[9:0] !== row[9:0], "running count");
    wait_refresh(60);
    check(raddr[25:14] === 12'hABC, "base bits");
    row = raddr[13:1];
    wait_refresh(60);
    check(raddr[13:1] === row + 13'h0001, "row advance");
    check(low_byte_enable_n_o === 1'b0, "enables pass through again");
    wb(1'b1, ADR_PIN_CONFIG_REGISTER, 16'h0000);
    pin_exp = 1'b1;
    wait_refresh(60);
    wb(1'b1, ADR_CONTROL, 16'h0000);
    repeat (10) @(posedge clk_i);
    repeat (100)
    begin
      @(posedge clk_i);
      if (refresh_n_o !== 1'b1)
        seen++;
    end
    check(seen == 0, "refresh while disabled");
    $display("test refresh done");
  endtask : t_refresh

  task automatic t_master(input logic dma);
    use_dma <= dma;
    wb(1'b1, ADR_INTERVAL, 16'h003C);
    wb(1'b1, ADR_CONTROL, 16'h8000);
    want <= 1'b1;
    wait_grant(60);
    wait_refresh(200);
    wait_grant(40);
    want <= 1'b0;
    wb(1'b1, ADR_CONTROL, 16'h0000);
    repeat (10) @(posedge clk_i);
    $display("test master %0d done", dma);
  endtask : t_master

  task automatic t_starve;
    int seen;
    int refs;
    seen = 0;
    refs = 0;
    use_dma <= 1'b0;
    wb(1'b1, ADR_INTERVAL, 16'h0005);
    wb(1'b1, ADR_CONTROL, 16'h8000);
    wait_refresh(40);
    want <= 1'b1;
    repeat (200)
    begin
      @(posedge clk_i);
      if (hold_acknowledge_o !== 1'b0)
        seen++;
      if (refresh_n_o === 1'b0)
        refs++;
    end
    check(seen == 0, "master got bus");
    check(refs > 20, "too few refreshes");
    want <= 1'b0;
    wb(1'b1, ADR_CONTROL, 16'h0000);
    $display("test short interval done");
  endtask : t_starve

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (20000) @(posedge clk_i);
    check(1'b0, "watchdog expired");
    summarize;
  end

  initial
  begin
    rst_i <= 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, want, use_dma} <= 5'h00;
    wb_adr_i <= 8'h00;
    wb_sel_i <= 4'h0;
    wb_dat_i <= 32'h0000_0000;
    {cpu_ble_n_i, cpu_bhe_n_i, chip_select_six_n_i} <= 3'b001;
    pin_exp = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_refresh;
    t_master(1'b0);
    t_master(1'b1);
    t_starve;
    summarize;
  end
endmodule : drf_refresh_ctrl_tb
